//--- thbc_params.svh
// Constants for the three-phase half-bridge control logic
`ifndef THBC_PARAMS_SVH
`define THBC_PARAMS_SVH
`define THBC_NUM_PHASES 3
`define THBC_DEAD_CYCLES 3
`define THBC_OSC_FREQ_KHZ 9000
`define THBC_OSC_TOL_PCT 30
`define THBC_OC_FILTER_NS 1000
`define THBC_OC_FILTER_CYC ((`THBC_OC_FILTER_NS * 250 + 999) / 1000)
`define THBC_RESTART_US 9900000
`define THBC_RESTART_CYC (64'(`THBC_RESTART_US) * 64'h00000000000000fa)
`endif

//--- thbc_pkg.sv
// Types for the three-phase half-bridge control logic
package thbc_pkg;
  typedef enum logic [1:0] {THBC_OUT_Z, THBC_OUT_LOW, THBC_OUT_HIGH}
    thbc_drive_t;
  typedef enum logic [1:0] {THBC_RUN, THBC_TRIP, THBC_WAIT} thbc_oc_state_t;
endpackage

//--- thbc_phase_if.sv
// Signals between the top and one phase channel
`timescale 1ns/10ps
interface thbc_phase_if;
  logic high_ctrl;
  logic low_ctrl;
  logic block;
  logic drive_high;
  logic drive_en;
  modport top (output high_ctrl, low_ctrl, block,
    input drive_high, drive_en);
  modport chan (input high_ctrl, low_ctrl, block,
    output drive_high, drive_en);
endinterface

//--- thbc_phase.sv
// One phase channel: decode and dead-time delay
`timescale 1ns/10ps
`include "thbc_params.svh"
module thbc_phase
  import thbc_pkg::*;
#(
  parameter int DEAD_CYCLES = `THBC_DEAD_CYCLES
)(
  input wire logic clk_in,
  input wire logic rst_in,
  thbc_phase_if.chan ph
);
  if (DEAD_CYCLES < 1 || DEAD_CYCLES > 15)
    $error("thbc_phase: DEAD_CYCLES out of range");
  thbc_drive_t target;
  thbc_drive_t out_q, out_d;
  thbc_drive_t pend_q, pend_d;
  logic [3:0] cnt_q, cnt_d;
  logic rise;
  logic hi_q, lo_q;
  always_comb
  begin
    // Decode of the two control inputs
    if (ph.high_ctrl && !ph.low_ctrl)
      target = THBC_OUT_HIGH;
    else if (!ph.high_ctrl && ph.low_ctrl)
      target = THBC_OUT_LOW;
    else
      target = THBC_OUT_Z;
  end
  assign rise = (ph.high_ctrl && !hi_q) || (ph.low_ctrl && !lo_q);
  always_comb
  begin
    out_d = out_q;
    pend_d = pend_q;
    cnt_d = cnt_q;
    if (ph.block)
    begin
      out_d = THBC_OUT_Z;
      pend_d = THBC_OUT_Z;
      cnt_d = 4'h0;
    end
    else if (rise)
    begin
      out_d = THBC_OUT_Z;
      pend_d = target;
      cnt_d = 4'(DEAD_CYCLES - 1);
    end
    else if (cnt_q != 4'h0)
    begin
      pend_d = target;
      cnt_d = cnt_q - 4'h1;
    end
    else if (target != pend_q && target != THBC_OUT_Z)
    begin
      pend_d = target;
      out_d = target;
    end
    else
    begin
      pend_d = target;
      out_d = target;
    end
  end
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      out_q <= THBC_OUT_Z;
      pend_q <= THBC_OUT_Z;
      cnt_q <= 4'h0;
      hi_q <= 1'b0;
      lo_q <= 1'b0;
    end
    else
    begin
      out_q <= out_d;
      pend_q <= pend_d;
      cnt_q <= cnt_d;
      hi_q <= ph.high_ctrl;
      lo_q <= ph.low_ctrl;
    end
  end
  assign ph.drive_high = (out_q == THBC_OUT_HIGH);
  assign ph.drive_en = (out_q != THBC_OUT_Z);
endmodule

//--- thbc_top.sv
// Three-phase half-bridge control: decode, dead time and protection
`timescale 1ns/10ps
`include "thbc_params.svh"
module thbc_top
  import thbc_pkg::*;
#(
  parameter int NUM_PHASES = `THBC_NUM_PHASES,
  parameter int DEAD_CYCLES = `THBC_DEAD_CYCLES,
  parameter int OC_FILTER_CYC = `THBC_OC_FILTER_CYC,
  parameter longint RESTART_CYC = `THBC_RESTART_CYC
)(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [2:0] high_side_ctrl_in,
  input wire logic [2:0] low_side_ctrl_in,
  input wire logic thermal_shutdown_in,
  input wire logic motor_supply_lockout_in,
  input wire logic regulator_lockout_in,
  input wire logic [2:0] high_side_overcurrent_in,
  input wire logic [2:0] low_side_overcurrent_in,
  output logic [2:0] phase_drive_high_out,
  output logic [2:0] phase_drive_en_out,
  output logic overcurrent_flag_pin_out,
  output logic overcurrent_flag_pin_oe_out,
  output logic thermal_flag_pin_out,
  output logic thermal_flag_pin_oe_out
);
  ////////////////////////////////////////////////////////////////////////
  // Elaboration checks
  if (NUM_PHASES != 3)
    $error("thbc_top: NUM_PHASES must be 3");
  if (OC_FILTER_CYC < 1 || OC_FILTER_CYC > 65535)
    $error("thbc_top: OC_FILTER_CYC out of range");
  if (RESTART_CYC < 1 || RESTART_CYC > 64'h0000_ffff_ffff)
    $error("thbc_top: RESTART_CYC out of range");
  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  // Pins pass two flops before any logic
  logic [13:0] sync1_q, sync2_q;
  logic [13:0] sync1_d, sync2_d;
  logic [13:0] raw;
  assign raw = {high_side_ctrl_in, low_side_ctrl_in,
    high_side_overcurrent_in, low_side_overcurrent_in,
    thermal_shutdown_in, motor_supply_lockout_in};
  logic reg_s1_q, reg_s2_q;
  logic reg_s1_d, reg_s2_d;
  // Regulator path starts locked so outputs stay released
  always_comb
  begin
    sync1_d = raw;
    sync2_d = sync1_q;
    reg_s1_d = regulator_lockout_in;
    reg_s2_d = reg_s1_q;
  end
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sync1_q <= 14'h0000;
      sync2_q <= 14'h0000;
      reg_s1_q <= 1'b1;
      reg_s2_q <= 1'b1;
    end
    else
    begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      reg_s1_q <= reg_s1_d;
      reg_s2_q <= reg_s2_d;
    end
  end
  logic [2:0] hi_s, lo_s, oc_hi_s, oc_lo_s;
  logic hot_s, motor_low_s;
  assign hi_s = sync2_q[13:11];
  assign lo_s = sync2_q[10:8];
  assign oc_hi_s = sync2_q[7:5];
  assign oc_lo_s = sync2_q[4:2];
  assign hot_s = sync2_q[1];
  assign motor_low_s = sync2_q[0];
  ////////////////////////////////////////////////////////////////////////
  // Overcurrent filter and restart timer
  logic [5:0] oc_det;
  assign oc_det = {oc_hi_s, oc_lo_s};
  logic [5:0][15:0] filt_q, filt_d;
  logic [5:0] filt_hit;
  // Six filters, one per transistor detector
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++)
    begin : g_filt
      always_comb
      begin
        if (!oc_det[gi])
          filt_d[gi] = 16'h0000;
        else if (filt_q[gi] != 16'(OC_FILTER_CYC))
          filt_d[gi] = filt_q[gi] + 16'h0001;
        else
          filt_d[gi] = filt_q[gi];
      end
      assign filt_hit[gi] = (filt_q[gi] == 16'(OC_FILTER_CYC));
    end
  endgenerate
  // Restart term counted in timebase cycles
  thbc_oc_state_t oc_q, oc_d;
  logic [39:0] rst_cnt_q, rst_cnt_d;
  always_comb
  begin
    oc_d = oc_q;
    rst_cnt_d = rst_cnt_q;
    case (oc_q)
      THBC_RUN:
      begin
        if (|filt_hit)
        begin
          oc_d = THBC_TRIP;
          rst_cnt_d = 40'(RESTART_CYC - 1);
        end
      end
      THBC_TRIP:
      begin
        if (rst_cnt_q == 40'h0)
          oc_d = THBC_WAIT;
        else
          rst_cnt_d = rst_cnt_q - 40'h1;
      end
      THBC_WAIT:
        oc_d = THBC_RUN;
      default:
        oc_d = THBC_RUN;
    endcase
  end
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      oc_q <= THBC_RUN;
      rst_cnt_q <= 40'h0;
    end
    else
    begin
      oc_q <= oc_d;
      rst_cnt_q <= rst_cnt_d;
    end
  end
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      filt_q <= '0;
    else
      filt_q <= filt_d;
  end
  logic oc_active;
  assign oc_active = (oc_q != THBC_RUN);
  ////////////////////////////////////////////////////////////////////////
  // Protection combine and flags
  logic block;
  assign block = oc_active || hot_s || motor_low_s || reg_s2_q;
  // Lockout release needs no command from the controller
  ////////////////////////////////////////////////////////////////////////
  // Open-drain flags, pulled low while over-temperature lasts or the overcurrent trip and restart term last
  logic oc_flag_q, hot_flag_q;
  logic oc_flag_d, hot_flag_d;
  always_comb
  begin
    oc_flag_d = oc_active;
    hot_flag_d = hot_s;
  end
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      oc_flag_q <= 1'b0;
      hot_flag_q <= 1'b0;
    end
    else
    begin
      oc_flag_q <= oc_flag_d;
      hot_flag_q <= hot_flag_d;
    end
  end
  assign overcurrent_flag_pin_out = 1'b0;
  assign overcurrent_flag_pin_oe_out = oc_flag_q;
  assign thermal_flag_pin_out = 1'b0;
  assign thermal_flag_pin_oe_out = hot_flag_q;
  ////////////////////////////////////////////////////////////////////////
  // Phase channels on the internal timebase
  // Release after protection skips the dead-time delay
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_phase
      thbc_phase_if ph_if ();
      assign ph_if.high_ctrl = hi_s[gi];
      assign ph_if.low_ctrl = lo_s[gi];
      assign ph_if.block = block;
      thbc_phase #(.DEAD_CYCLES(DEAD_CYCLES)) u_phase (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .ph(ph_if.chan)
      );
      assign phase_drive_high_out[gi] = ph_if.drive_high;
      assign phase_drive_en_out[gi] = ph_if.drive_en;
    end
  endgenerate
endmodule

//--- thbc_ctrl_model.sv
// Controller model for the six phase control pins
`timescale 1ns/10ps
module thbc_ctrl_model (
  input wire logic clk_in,
  input wire logic off_in,
  input wire logic [5:0] cmd_in,
  output logic [5:0] pins_out = 6'h0
);
  // Pins held low while the motor supply is off
  always @(posedge clk_in)
    pins_out <= off_in ? 6'h0 : cmd_in;
endmodule

//--- thbc_top_sva.sv
// Port assertions for the half-bridge control
`timescale 1ns/10ps
module thbc_top_sva (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [2:0] high_side_ctrl_in,
  input wire logic [2:0] low_side_ctrl_in,
  input wire logic thermal_shutdown_in,
  input wire logic motor_supply_lockout_in,
  input wire logic regulator_lockout_in,
  input wire logic [2:0] high_side_overcurrent_in,
  input wire logic [2:0] low_side_overcurrent_in,
  input wire logic [2:0] phase_drive_high_out,
  input wire logic [2:0] phase_drive_en_out,
  input wire logic overcurrent_flag_pin_out,
  input wire logic overcurrent_flag_pin_oe_out,
  input wire logic thermal_flag_pin_out,
  input wire logic thermal_flag_pin_oe_out
);
  wire [2:0] h = high_side_ctrl_in;
  wire [2:0] en = phase_drive_en_out;
  wire oe = overcurrent_flag_pin_oe_out;
  wire oc = |{high_side_overcurrent_in, low_side_overcurrent_in};
  wire p = thermal_shutdown_in | motor_supply_lockout_in | oc | oe |
    regulator_lockout_in;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence s_rise;
    !en[0] && $rose(h[0]) && !low_side_ctrl_in[0];
  endsequence
  sequence s_hi;
    (h[0] && !low_side_ctrl_in[0] && !p)[*8];
  endsequence
  ////////////////////////////////////////////////////////////////////////
  a_hot_hiz: assert property (thermal_shutdown_in[*3] |=> en == 3'h0)
    else $error("hot not hi-z");
  a_hot_flag: assert property (thermal_shutdown_in[*3] |=>
    thermal_flag_pin_oe_out) else $error("hot flag");
  a_motor_hiz: assert property (motor_supply_lockout_in[*3] |=>
    en == 3'h0) else $error("motor not hi-z");
  a_reg_hiz: assert property (regulator_lockout_in[*3] |=>
    en == 3'h0) else $error("reg not hi-z");
  a_oc_hiz: assert property (oe && $past(oe) |-> en == 3'h0)
    else $error("trip not hi-z");
  a_oc_flag: assert property (oc[*7] |-> ##[0:5] oe)
    else $error("trip flag");
  a_flag_data: assert property (!overcurrent_flag_pin_out &&
    !thermal_flag_pin_out) else $error("flag data");
  a_dead_hold: assert property (s_rise |-> (!en[0])[*6] ##1 en[0])
    else $error("dead time short");
  a_drive_high: assert property (s_hi |=> en[0] &&
    phase_drive_high_out[0]) else $error("no drive");
endmodule
bind thbc_top thbc_top_sva u_sva (.*);

//--- thbc_top_test.sv
// Self-checking bench for the half-bridge control
`timescale 1ns/10ps
module thbc_top_test;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [5:0] cmd = 6'h0;
  logic [5:0] pin;
  logic [2:0] prot = 3'h0;
  logic [5:0] oc = 6'h0;
  logic [2:0] en, dh;
  logic ocf, oco, thf, tho;
  int bad_count = 0;
  int n_compared = 0;
  wire [7:0] res = {en, dh & en, oco, tho};
  always #2 clk_in = ~clk_in;
  thbc_ctrl_model i_ctrl (.clk_in(clk_in), .off_in(prot[1]),
    .cmd_in(cmd), .pins_out(pin));
  thbc_top #(.OC_FILTER_CYC(4), .RESTART_CYC(20)) i_dut (
    .clk_in(clk_in), .rst_in(rst_in), .high_side_ctrl_in(pin[5:3]),
    .low_side_ctrl_in(pin[2:0]), .thermal_shutdown_in(prot[2]),
    .motor_supply_lockout_in(prot[1]), .regulator_lockout_in(prot[0]),
    .high_side_overcurrent_in(oc[2:0]),
    .low_side_overcurrent_in(oc[5:3]), .phase_drive_high_out(dh),
    .phase_drive_en_out(en), .overcurrent_flag_pin_out(ocf),
    .overcurrent_flag_pin_oe_out(oco), .thermal_flag_pin_out(thf),
    .thermal_flag_pin_oe_out(tho));
  task automatic w(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic drv(input logic [5:0] c);
    @(posedge clk_in);
    cmd <= c;
  endtask
  task automatic chk(input logic [7:0] e);
    n_compared++;
    if (res !== e)
    begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, res, e);
    end
  endtask
  task automatic chk_od(input logic [1:0] e);
    n_compared++;
    if ({ocf, thf} !== e)
    begin
      bad_count++;
      $display("[ERR] %0t flag data %b exp %b", $time, {ocf, thf}, e);
    end
  endtask
  task automatic end_sim();
    $display("compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_decode();
    for (int v = 0; v < 64; v++)
    begin
      drv(v[5:0]);
      w(10);
      chk({v[5:3] ^ v[2:0], v[5:3] & ~v[2:0], 2'h0});
    end
  endtask
  task automatic t_dead();
    drv(6'h0);
    w(10);
    drv(6'h10);
    w(7);
    chk(8'h0);
    w(1);
    chk(8'h48);
  endtask
  task automatic t_prot();
    for (int k = 0; k < 3; k++)
    begin
      drv(6'h0a);
      w(10);
      @(posedge clk_in);
      prot <= 3'h4 >> k;
      w(6);
      chk({7'h0, k == 0});
      chk_od(2'h0);
      @(posedge clk_in);
      prot <= 3'h0;
      w(12);
      chk(8'h64);
    end
  endtask
  task automatic t_oc();
    for (int k = 0; k < 6; k++)
    begin
      int i;
      @(posedge clk_in);
      oc <= 6'h1 << k;
      for (i = 0; i < 20 && oco !== 1'b1; i++)
        w(1);
      if (i == 20)
      begin
        bad_count++;
        end_sim();
      end
      chk(8'h02);
      @(posedge clk_in);
      oc <= 6'h0;
      w(8);
      chk(8'h02);
      w(12);
      chk(8'h02);
      w(1);
      chk(8'h64);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    w(4);
    @(posedge clk_in);
    rst_in <= 1'b0;
    t_decode();
    t_dead();
    t_prot();
    t_oc();
    end_sim();
  end
  initial
  begin
    #100000;
    bad_count++;
    end_sim();
  end
endmodule
